// *** hw/host_mailbox_regs.vh ***
`ifndef HOST_MAILBOX_REGS_VH
`define HOST_MAILBOX_REGS_VH

// data width of every register in the set
`define BYTE_W            8
`define BYTE_ZERO         8'h00
`define BYTE_ONES         8'hff
`define ADDR_STEP         8'h01

// write-side byte addresses
`define WA_CONFIG         8'h00
`define WA_IRQ_BLOCK_0    8'h01
`define WA_IRQ_BLOCK_1    8'h02
`define WA_QUEUE          8'h10
`define WA_ARG_BASE_HI    4'h2
`define WA_COMMAND_0      8'h30
`define WA_COMMAND_1      8'h31
`define WA_SUBMIT         8'h32

// read-side byte addresses
`define RA_CONFIG         8'h80
`define RA_IRQ_BLOCK_0    8'h81
`define RA_IRQ_BLOCK_1    8'h82
`define RA_MEAS_STATE     8'h83
`define RA_FAULT_0        8'h84
`define RA_FAULT_1        8'h85
`define RA_IRQ_SOURCE_0   8'h86
`define RA_IRQ_SOURCE_1   8'h87
`define RA_QUEUE          8'h90
`define RA_ARG_BASE_HI    4'ha
`define RA_COMMAND_0      8'hb0
`define RA_COMMAND_1      8'hb1
`define RA_SUBMIT         8'hb2
`define RA_OUTCOME_HI     2'h3

// configuration and submit fields
`define CFG_HOLD_BIT      7
`define SUBMIT_BIT        0

// banks and queue geometry
`define ARG_COUNT         16
`define ARG_IDX_W         4
`define OUTCOME_COUNT     64
`define OUTCOME_IDX_W     6
`define QUEUE_DEPTH       512
`define QUEUE_PTR_W       9
`define QUEUE_CNT_W       10
`define QUEUE_PTR_ONE     9'h001
`define QUEUE_CNT_ONE     10'h001
`define QUEUE_FULL_CNT    10'h200

`endif

// *** hw/sticky_byte.v ***
`include "host_mailbox_regs.vh"

// eight flags set by the cpu, cleared by a host read of the byte
module sticky_byte (
  input  wire                core_clk_in,
  input  wire                rst_n_in,
  input  wire [`BYTE_W-1:0]  set_in,
  input  wire                clear_in,
  output wire [`BYTE_W-1:0]  value_out
);

  reg [`BYTE_W-1:0] flag;

  ////////////////////////////////////////////////////////////////////////////
  // one flop per bit; a set landing with the read-clear survives
  genvar i;
  generate
    for (i = 0; i < `BYTE_W; i = i + 1) begin : g_bit
      always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
          flag[i] <= 1'b0;
        end else begin
          flag[i] <= set_in[i] | (flag[i] & ~clear_in);
        end
      end
    end
  endgenerate

  assign value_out = flag;

endmodule // sticky_byte

// *** hw/byte_queue.v ***
`include "host_mailbox_regs.vh"

// byte queue, head visible without a pop
module byte_queue (
  input  wire                core_clk_in,
  input  wire                rst_n_in,
  input  wire                push_in,
  input  wire [`BYTE_W-1:0]  push_data_in,
  output wire                push_ready_out,
  input  wire                pop_in,
  output wire [`BYTE_W-1:0]  head_out,
  output wire                head_valid_out
);

  reg [`BYTE_W-1:0]      mem [0:`QUEUE_DEPTH-1];
  reg [`QUEUE_PTR_W-1:0] wr_ptr;
  reg [`QUEUE_PTR_W-1:0] rd_ptr;
  reg [`QUEUE_CNT_W-1:0] count;
  wire                   do_push;
  wire                   do_pop;

  // pushes when full and pops when empty are dropped
  assign push_ready_out = (count != `QUEUE_FULL_CNT);
  assign head_valid_out = (count != {`QUEUE_CNT_W{1'b0}});
  assign do_push        = push_in & push_ready_out;
  assign do_pop         = pop_in & head_valid_out;
  assign head_out       = head_valid_out ? mem[rd_ptr] : `BYTE_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // storage is not reset; only the pointers and the fill count are
  always @(posedge core_clk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_in;
    end
  end

  // pointers and fill count
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wr_ptr <= {`QUEUE_PTR_W{1'b0}};
      rd_ptr <= {`QUEUE_PTR_W{1'b0}};
      count  <= {`QUEUE_CNT_W{1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + `QUEUE_PTR_ONE;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + `QUEUE_PTR_ONE;
      end
      if (do_push && !do_pop) begin
        count <= count + `QUEUE_CNT_ONE;
      end else if (do_pop && !do_push) begin
        count <= count - `QUEUE_CNT_ONE;
      end
    end
  end

endmodule // byte_queue

// *** hw/host_command_mailbox_regs.v ***
// Function
// - read-only 8-bit measurement state, reset zero, shown to the host.
// - two read-only fault code bytes, reset zero, cleared when the host reads them.
// - two read-only interrupt source bytes, reset zero, cleared by host read.
// - result queue port; each host read pops one byte, a read of an empty queue returns zero and pops nothing.
// - firmware data written into the queue port, blocks of at most 512 bytes.
// - sixteen read-write argument bytes, reset zero.
// - two read-write command bytes, reset zero.
// - submit bit cleared when the cpu takes the command.
// - submit register implements bit 0 only; upper bits read zero.
// - sixty-four read-only outcome bytes written by the cpu, reset zero.
// - link address increments per byte unless the address hold bit is one.
// - mask bit one blocks that source from notifying the host; masks reset ones.
`include "host_mailbox_regs.vh"

module host_command_mailbox_regs (
  input  wire                 core_clk_in,
  input  wire                 rst_n_in,
  // byte-level host link, already deframed on this clock
  input  wire                 link_start_in,
  input  wire [7:0]           link_addr_in,
  input  wire                 link_wr_in,
  input  wire [7:0]           link_wdata_in,
  input  wire                 link_rd_in,
  output reg  [7:0]           link_rdata_out,
  output reg                  link_rvalid_out,
  output reg                  host_irq_out,
  // internal cpu side
  input  wire [7:0]           cpu_meas_state_in,
  input  wire [7:0]           cpu_fault_0_set_in,
  input  wire [7:0]           cpu_fault_1_set_in,
  input  wire [7:0]           cpu_irq_0_set_in,
  input  wire [7:0]           cpu_irq_1_set_in,
  input  wire                 cpu_cmd_taken_in,
  input  wire                 cpu_outcome_we_in,
  input  wire [5:0]           cpu_outcome_idx_in,
  input  wire [7:0]           cpu_outcome_data_in,
  input  wire                 cpu_result_push_in,
  input  wire [7:0]           cpu_result_data_in,
  output wire                 cpu_result_ready_out,
  input  wire                 cpu_update_pop_in,
  output wire [7:0]           cpu_update_data_out,
  output wire                 cpu_update_valid_out,
  output reg  [7:0]           command_word_0_out,
  output reg  [7:0]           command_word_1_out,
  output wire [127:0]         command_argument_out,
  output wire                 command_submit_flag_out,
  output wire                 address_hold_select_out
);

  reg  [7:0] config_reg;
  reg  [7:0] host_irq_block_0;
  reg  [7:0] host_irq_block_1;
  reg  [7:0] measurement_state_bits;
  reg  [7:0] command_argument [0:`ARG_COUNT-1];
  reg  [7:0] outcome_byte [0:`OUTCOME_COUNT-1];
  reg        submit_flag;
  reg  [7:0] cur_addr;
  wire [7:0] eff_addr;
  wire       access;
  wire       wr_arg;
  wire       rd_arg;
  wire       rd_outcome;
  wire [`ARG_IDX_W-1:0] arg_idx;
  wire [7:0] fault_0;
  wire [7:0] fault_1;
  wire [7:0] irq_src_0;
  wire [7:0] irq_src_1;
  wire [7:0] result_head;
  wire       result_valid;
  wire       rd_queue;
  wire       wr_queue;
  reg  [7:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // link addressing: a start loads the address, later bytes reuse cur_addr
  assign eff_addr = link_start_in ? link_addr_in : cur_addr;
  assign access   = link_wr_in | link_rd_in;

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cur_addr <= `BYTE_ZERO;
    end else if (access) begin
      if (config_reg[`CFG_HOLD_BIT]) begin
        cur_addr <= eff_addr;
      end else begin
        cur_addr <= eff_addr + `ADDR_STEP;
      end
    end else if (link_start_in) begin
      cur_addr <= link_addr_in;
    end
  end

  assign address_hold_select_out = config_reg[`CFG_HOLD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // decode; argument 00 sits at the top of its row, so the index is inverted
  assign arg_idx    = ~eff_addr[3:0];
  assign wr_arg     = link_wr_in & (eff_addr[7:4] == `WA_ARG_BASE_HI);
  assign rd_arg     = eff_addr[7:4] == `RA_ARG_BASE_HI;
  assign rd_outcome = eff_addr[7:6] == `RA_OUTCOME_HI;
  assign rd_queue   = link_rd_in & (eff_addr == `RA_QUEUE);
  assign wr_queue   = link_wr_in & (eff_addr == `WA_QUEUE);

  ////////////////////////////////////////////////////////////////////////////
  // host-writable control; anything else written is dropped here
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      config_reg         <= `BYTE_ZERO;
      host_irq_block_0   <= `BYTE_ONES;
      host_irq_block_1   <= `BYTE_ONES;
      command_word_0_out <= `BYTE_ZERO;
      command_word_1_out <= `BYTE_ZERO;
    end else if (link_wr_in) begin
      case (eff_addr)
        `WA_CONFIG: begin
          config_reg <= link_wdata_in;
        end
        `WA_IRQ_BLOCK_0: begin
          host_irq_block_0 <= link_wdata_in;
        end
        `WA_IRQ_BLOCK_1: begin
          host_irq_block_1 <= link_wdata_in;
        end
        `WA_COMMAND_0: begin
          command_word_0_out <= link_wdata_in;
        end
        `WA_COMMAND_1: begin
          command_word_1_out <= link_wdata_in;
        end
        default: begin
          config_reg <= config_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // argument bank, one flop byte per entry
  genvar g;
  generate
    for (g = 0; g < `ARG_COUNT; g = g + 1) begin : g_arg
      always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
          command_argument[g] <= `BYTE_ZERO;
        end else if (wr_arg && (arg_idx == g)) begin
          command_argument[g] <= link_wdata_in;
        end
      end
      assign command_argument_out[g*`BYTE_W +: `BYTE_W] = command_argument[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // submit flag: host sets, cpu clears; a new set beats a same-cycle take.
  // writing zero has no effect so the host cannot withdraw a command.
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      submit_flag <= 1'b0;
    end else if (link_wr_in && (eff_addr == `WA_SUBMIT) && link_wdata_in[`SUBMIT_BIT]) begin
      submit_flag <= 1'b1;
    end else if (cpu_cmd_taken_in) begin
      submit_flag <= 1'b0;
    end
  end

  assign command_submit_flag_out = submit_flag;

  ////////////////////////////////////////////////////////////////////////////
  // cpu-owned state: measurement progress and the outcome bank
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      measurement_state_bits <= `BYTE_ZERO;
    end else begin
      measurement_state_bits <= cpu_meas_state_in;
    end
  end

  generate
    for (g = 0; g < `OUTCOME_COUNT; g = g + 1) begin : g_outcome
      always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
          outcome_byte[g] <= `BYTE_ZERO;
        end else if (cpu_outcome_we_in && (cpu_outcome_idx_in == g)) begin
          outcome_byte[g] <= cpu_outcome_data_in;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // clear-on-read flags; only a read clears, a write to them is ignored
  sticky_byte u_fault_0 (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (cpu_fault_0_set_in),
    .clear_in    (link_rd_in & (eff_addr == `RA_FAULT_0)),
    .value_out   (fault_0)
  );

  sticky_byte u_fault_1 (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (cpu_fault_1_set_in),
    .clear_in    (link_rd_in & (eff_addr == `RA_FAULT_1)),
    .value_out   (fault_1)
  );

  sticky_byte u_irq_src_0 (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (cpu_irq_0_set_in),
    .clear_in    (link_rd_in & (eff_addr == `RA_IRQ_SOURCE_0)),
    .value_out   (irq_src_0)
  );

  sticky_byte u_irq_src_1 (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (cpu_irq_1_set_in),
    .clear_in    (link_rd_in & (eff_addr == `RA_IRQ_SOURCE_1)),
    .value_out   (irq_src_1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // results toward the host; a read of an empty queue returns zero
  byte_queue u_result_q (
    .core_clk_in    (core_clk_in),
    .rst_n_in       (rst_n_in),
    .push_in        (cpu_result_push_in),
    .push_data_in   (cpu_result_data_in),
    .push_ready_out (cpu_result_ready_out),
    .pop_in         (rd_queue),
    .head_out       (result_head),
    .head_valid_out (result_valid)
  );

  // firmware bytes toward the cpu; one block fits, bytes past full are lost
  byte_queue u_update_q (
    .core_clk_in    (core_clk_in),
    .rst_n_in       (rst_n_in),
    .push_in        (wr_queue),
    .push_data_in   (link_wdata_in),
    .push_ready_out (),
    .pop_in         (cpu_update_pop_in),
    .head_out       (cpu_update_data_out),
    .head_valid_out (cpu_update_valid_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux; value is sampled before any clear-on-read takes effect
  always @* begin
    next_rdata = `BYTE_ZERO;
    if (rd_arg) begin
      next_rdata = command_argument[arg_idx];
    end else if (rd_outcome) begin
      next_rdata = outcome_byte[eff_addr[`OUTCOME_IDX_W-1:0]];
    end else begin
      case (eff_addr)
        `RA_CONFIG:       next_rdata = config_reg;
        `RA_IRQ_BLOCK_0:  next_rdata = host_irq_block_0;
        `RA_IRQ_BLOCK_1:  next_rdata = host_irq_block_1;
        `RA_MEAS_STATE:   next_rdata = measurement_state_bits;
        `RA_FAULT_0:      next_rdata = fault_0;
        `RA_FAULT_1:      next_rdata = fault_1;
        `RA_IRQ_SOURCE_0: next_rdata = irq_src_0;
        `RA_IRQ_SOURCE_1: next_rdata = irq_src_1;
        `RA_QUEUE:        next_rdata = result_valid ? result_head : `BYTE_ZERO;
        `RA_COMMAND_0:    next_rdata = command_word_0_out;
        `RA_COMMAND_1:    next_rdata = command_word_1_out;
        `RA_SUBMIT:       next_rdata = {7'h00, submit_flag};
        default:          next_rdata = `BYTE_ZERO;
      endcase
    end
  end

  // read answer one cycle after the strobe
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      link_rdata_out  <= `BYTE_ZERO;
      link_rvalid_out <= 1'b0;
    end else begin
      link_rvalid_out <= link_rd_in;
      if (link_rd_in) begin
        link_rdata_out <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host interrupt level, registered to keep the pin glitch free
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      host_irq_out <= 1'b0;
    end else begin
      host_irq_out <= (|(irq_src_0 & ~host_irq_block_0)) |
                      (|(irq_src_1 & ~host_irq_block_1));
    end
  end

endmodule // host_command_mailbox_regs

// *** verification/host_mailbox_monitor.sv ***
module host_mailbox_monitor (
  input wire logic         core_clk_in,
  input wire logic         rst_n_in,
  input wire logic         link_start_in,
  input wire logic [7:0]   link_addr_in,
  input wire logic         link_wr_in,
  input wire logic [7:0]   link_wdata_in,
  input wire logic         link_rd_in,
  input wire logic [7:0]   link_rdata_out,
  input wire logic         link_rvalid_out,
  input wire logic         host_irq_out,
  input wire logic         cpu_cmd_taken_in,
  input wire logic [7:0]   command_word_0_out,
  input wire logic [7:0]   command_word_1_out,
  input wire logic [127:0] command_argument_out,
  input wire logic         command_submit_flag_out,
  input wire logic         address_hold_select_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  ////////////////////////////////////////
  // masks come up all ones, so no source can notify before the first host write
  logic any_wr;
  logic start_wr;
  always @(posedge core_clk_in) begin
    if (!rst_n_in)
      any_wr <= 1'b0;
    else if (link_wr_in)
      any_wr <= 1'b1;
  end
  assign start_wr = link_start_in & link_wr_in;

  ////////////////////////////////////////
  chk_rvalid_pulse: assert property (link_rd_in |=> link_rvalid_out)
    else $error("read not answered one cycle later");
  chk_rdata_hold: assert property (!link_rd_in |=> $stable(link_rdata_out))
    else $error("read data moved without a read");
  chk_irq_masked: assert property (!any_wr |-> !host_irq_out)
    else $error("interrupt raised while all sources masked");
  chk_submit_take: assert property (cpu_cmd_taken_in && !link_wr_in |=> !command_submit_flag_out)
    else $error("submit flag survived cpu take");
  chk_submit_set: assert property (start_wr && link_addr_in == 8'h32 && link_wdata_in[0] |=> command_submit_flag_out)
    else $error("submit flag not set by host write");
  chk_cmd_write: assert property (start_wr && link_addr_in == 8'h30 |=> command_word_0_out == $past(link_wdata_in))
    else $error("command word 0 not written");
  chk_arg_write: assert property (start_wr && link_addr_in == 8'h2f |=> command_argument_out[7:0] == $past(link_wdata_in))
    else $error("argument 0 not written");
  chk_cmd_quiet: assert property (!link_wr_in |=> $stable({command_word_0_out, command_word_1_out, command_argument_out}))
    else $error("command bytes changed without a write");
  chk_hold_write: assert property (start_wr && link_addr_in == 8'h00 |=> address_hold_select_out == $past(link_wdata_in[7]))
    else $error("address hold bit not written");

  cover property (start_wr && link_addr_in == 8'h32);
  cover property (host_irq_out);
  cover property (link_rvalid_out && link_rdata_out != 8'h00);
endmodule // host_mailbox_monitor

// *** verification/host_link_model.sv ***
module host_link_model (
  input  wire logic       core_clk_in,
  output logic            link_start_out,
  output logic [7:0]      link_addr_out,
  output logic            link_wr_out,
  output logic [7:0]      link_wdata_out,
  output logic            link_rd_out,
  input  wire logic [7:0] link_rdata_in,
  input  wire logic       link_rvalid_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    link_start_out = 1'b0;
    link_addr_out  = 8'h00;
    link_wr_out    = 1'b0;
    link_wdata_out = 8'h00;
    link_rd_out    = 1'b0;
  end

  ////////////////////////////////////////
  // released lines show the inverse so a stale value can never pass for a fresh one
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s);
    @(posedge core_clk_in);
    link_start_out <= s;
    link_addr_out  <= a;
    link_wr_out    <= 1'b1;
    link_wdata_out <= d;
    @(posedge core_clk_in);
    link_start_out <= 1'b0;
    link_wr_out    <= 1'b0;
    link_addr_out  <= ~a;
    link_wdata_out <= ~d;
  endtask

  // answer is taken at the edge after the taking edge; a missing valid returns unknowns
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    link_start_out <= 1'b1;
    link_addr_out  <= a;
    link_rd_out    <= 1'b1;
    @(posedge core_clk_in);
    link_start_out <= 1'b0;
    link_rd_out    <= 1'b0;
    link_addr_out  <= ~a;
    @(posedge core_clk_in);
    d = link_rvalid_in ? link_rdata_in : 8'hxx;
  endtask
endmodule // host_link_model

// *** verification/host_command_mailbox_regs_bench.sv ***
module host_command_mailbox_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic         core_clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  logic         link_start_in, link_wr_in, link_rd_in, link_rvalid_out, host_irq_out;
  logic [7:0]   link_addr_in, link_wdata_in, link_rdata_out, got;
  logic [7:0]   cpu_meas_state_in = 8'h00, cpu_fault_0_set_in = 8'h00, cpu_fault_1_set_in = 8'h00;
  logic [7:0]   cpu_irq_0_set_in = 8'h00, cpu_irq_1_set_in = 8'h00;
  logic         cpu_cmd_taken_in = 1'b0, cpu_outcome_we_in = 1'b0, cpu_result_push_in = 1'b0;
  logic         cpu_update_pop_in = 1'b0, cpu_result_ready_out, cpu_update_valid_out;
  logic [5:0]   cpu_outcome_idx_in = 6'h00;
  logic [7:0]   cpu_outcome_data_in = 8'h00, cpu_result_data_in = 8'h00, cpu_update_data_out;
  logic [7:0]   command_word_0_out, command_word_1_out;
  logic [127:0] command_argument_out;
  logic         command_submit_flag_out, address_hold_select_out;
  int           num_errors = 0;
  int           n_compared = 0;
  int           i, n;

  always #5 core_clk_in = ~core_clk_in;

  host_command_mailbox_regs i_dut (.core_clk_in, .rst_n_in, .link_start_in, .link_addr_in, .link_wr_in,
    .link_wdata_in, .link_rd_in, .link_rdata_out, .link_rvalid_out, .host_irq_out, .cpu_meas_state_in,
    .cpu_fault_0_set_in, .cpu_fault_1_set_in, .cpu_irq_0_set_in, .cpu_irq_1_set_in, .cpu_cmd_taken_in,
    .cpu_outcome_we_in, .cpu_outcome_idx_in, .cpu_outcome_data_in, .cpu_result_push_in, .cpu_result_data_in,
    .cpu_result_ready_out, .cpu_update_pop_in, .cpu_update_data_out, .cpu_update_valid_out, .command_word_0_out,
    .command_word_1_out, .command_argument_out, .command_submit_flag_out, .address_hold_select_out);

  host_link_model i_host (.core_clk_in, .link_start_out(link_start_in), .link_addr_out(link_addr_in),
    .link_wr_out(link_wr_in), .link_wdata_out(link_wdata_in), .link_rd_out(link_rd_in),
    .link_rdata_in(link_rdata_out), .link_rvalid_in(link_rvalid_out));

  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
      begin num_errors++; $display("Error at %0t: saw %h, expected %h", $time, seen, exp); end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, got);
    check(got, e);
  endtask

  // let the edge's updates land before looking
  task automatic settle;
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic give_verdict;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////
  // hang guard, well beyond the roughly 4300 cycles the sequence needs
  initial begin
    repeat (12000) @(posedge core_clk_in);
    num_errors++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    // reset values, masks come up all ones
    for (i = 3; i < 8; i++) rdchk(8'h80 + i[7:0], 8'h00);
    rdchk(8'h81, 8'hff);
    rdchk(8'h82, 8'hff);
    rdchk(8'ha3, 8'h00);
    rdchk(8'hb1, 8'h00);
    rdchk(8'hb2, 8'h00);
    rdchk(8'hc5, 8'h00);
    // one start, then the address walks the argument bank, both commands and submit
    for (i = 0; i < 19; i++) i_host.wr(8'h20, (i == 18) ? 8'hff : 8'h40 + i[7:0], i == 0);
    settle();
    for (i = 0; i < 16; i++) check(command_argument_out[8*(15-i) +: 8], 8'h40 + i[7:0]);
    check(command_word_0_out, 8'h50);
    check(command_word_1_out, 8'h51);
    rdchk(8'hb2, 8'h01);
    rdchk(8'haf, 8'h4f);
    @(posedge core_clk_in) cpu_cmd_taken_in <= 1'b1;
    @(posedge core_clk_in) cpu_cmd_taken_in <= 1'b0;
    rdchk(8'hb2, 8'h00);
    // direct starts on argument 00 and submit; a zero write must not withdraw the command
    i_host.wr(8'h2f, 8'h9c, 1'b1);
    i_host.wr(8'h32, 8'h01, 1'b1);
    i_host.wr(8'h32, 8'h00, 1'b1);
    rdchk(8'hb2, 8'h01);
    rdchk(8'haf, 8'h9c);
    @(posedge core_clk_in) cpu_cmd_taken_in <= 1'b1;
    @(posedge core_clk_in) cpu_cmd_taken_in <= 1'b0;
    rdchk(8'hb2, 8'h00);
    // address hold: the second write lands on the same command byte
    i_host.wr(8'h00, 8'h80, 1'b1);
    rdchk(8'h80, 8'h80);
    i_host.wr(8'h30, 8'h11, 1'b1);
    i_host.wr(8'h00, 8'h22, 1'b0);
    settle();
    check(command_word_0_out, 8'h22);
    check(command_word_1_out, 8'h51);
    i_host.wr(8'h00, 8'h00, 1'b1);
    // sticky bytes: a host write is ignored, the first read returns and clears
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk_in);
      {cpu_irq_1_set_in, cpu_irq_0_set_in, cpu_fault_1_set_in, cpu_fault_0_set_in} <= 32'h5a << (8 * i);
      @(posedge core_clk_in);
      {cpu_irq_1_set_in, cpu_irq_0_set_in, cpu_fault_1_set_in, cpu_fault_0_set_in} <= 32'h0;
      i_host.wr(8'h84 + i[7:0], 8'hff, 1'b1);
      rdchk(8'h84 + i[7:0], 8'h5a);
      rdchk(8'h84 + i[7:0], 8'h00);
    end
    // interrupt: masked, unmasked, cleared by reading its source
    @(posedge core_clk_in) cpu_irq_0_set_in <= 8'h08;
    @(posedge core_clk_in) cpu_irq_0_set_in <= 8'h00;
    settle();
    check(host_irq_out, 1'b0);
    i_host.wr(8'h01, 8'hf7, 1'b1);
    settle();
    check(host_irq_out, 1'b1);
    rdchk(8'h86, 8'h08);
    settle();
    check(host_irq_out, 1'b0);
    // result queue: cpu fills until refused, host drains exactly that many, room again
    for (i = 0; i < 512; i++) @(posedge core_clk_in) {cpu_result_push_in, cpu_result_data_in} <= {1'b1, i[7:0]};
    @(posedge core_clk_in) cpu_result_push_in <= 1'b0;
    #1 check(cpu_result_ready_out, 1'b0);
    for (i = 0; i < 512; i++) rdchk(8'h90, i[7:0]);
    check(cpu_result_ready_out, 1'b1);
    // firmware block: the host keeps to one full block, all 512 reach the cpu in order
    for (i = 0; i < 512; i++) i_host.wr(8'h10, i[7:0] ^ 8'h33, 1'b1);
    settle();
    for (n = 0; cpu_update_valid_out === 1'b1 && n < 600; n++) begin
      check(cpu_update_data_out, n[7:0] ^ 8'h33);
      @(posedge core_clk_in) cpu_update_pop_in <= 1'b1;
      @(posedge core_clk_in) cpu_update_pop_in <= 1'b0;
      #1;
    end
    check(n[15:0], 16'h0200);
    // outcome bank top entry and measurement state from the cpu
    @(posedge core_clk_in) {cpu_outcome_we_in, cpu_outcome_idx_in, cpu_outcome_data_in} <= {1'b1, 6'h3f, 8'h77};
    @(posedge core_clk_in) {cpu_outcome_we_in, cpu_meas_state_in} <= {1'b0, 8'hc3};
    i_host.wr(8'hff, 8'h00, 1'b1);
    rdchk(8'hff, 8'h77);
    rdchk(8'h83, 8'hc3);
    give_verdict();
  end
endmodule // host_command_mailbox_regs_bench

bind host_command_mailbox_regs host_mailbox_monitor i_mon (.core_clk_in, .rst_n_in, .link_start_in, .link_addr_in,
  .link_wr_in, .link_wdata_in, .link_rd_in, .link_rdata_out, .link_rvalid_out, .host_irq_out, .cpu_cmd_taken_in,
  .command_word_0_out, .command_word_1_out, .command_argument_out, .command_submit_flag_out, .address_hold_select_out);
